// file: rstboot_map.vh
// Purpose: constants for the reset, boot-mode and interrupt-pin block
// Assumes: 100 MHz clock, 8-bit register port
// Notes: offsets are word indices on the plain register port
//
// Operation
// - Stop/wait: interrupt pins wake without clock
// - Otherwise interrupt pins pass a synchroniser
// - Each interrupt pin: low level or falling edge
// - Reset pin low holds device in reset
// - Boot strap captured as reset releases
// - Internal reset released synchronously after delay
// - Device reset leaves debug module untouched
// - Power-on reset asserts independently of pin
// - Reset output follows internal reset state
// - Strap high boots external unless flash secure
// - Memory mode strap selects 20-bit address bus
// - Pull-up disable bits turn off pin pull-ups
// - Cleared port E enable bit removes pull-up
// - Timer D pins reset to timer, GPIO-capable
// - Secure flash forces internal boot, mode 00
// - External boot: memory interface follows strap
`ifndef RSTBOOT_MAP_VH
`define RSTBOOT_MAP_VH

// ----------------------------------------
// Register offsets
// ----------------------------------------
`define RB_ADDR_PUDIS 3'h0
`define RB_ADDR_PE_PU 3'h1
`define RB_ADDR_TD_CTL 3'h2
`define RB_ADDR_IRQ_CFG 3'h3
`define RB_ADDR_IRQ_STAT 3'h4
`define RB_ADDR_IRQ_MASK 3'h5
`define RB_ADDR_MODE 3'h6

// ----------------------------------------
// Fields and reset values
// ----------------------------------------
`define RB_PUDIS_IRQ 0
`define RB_PUDIS_RESET 1
`define RB_PUDIS_BOOT 2
`define RB_PUDIS_MEMMODE 3
`define RB_PUDIS_RST 4'h0
`define RB_PE_PU_RST 2'h3
`define RB_TD_CTL_RST 6'h00
`define RB_IRQ_CFG_RST 2'h0
`define RB_IRQ_MASK_RST 2'h0

// ----------------------------------------
// Timing
// ----------------------------------------
`define RB_RST_DLY_CYC 64

`endif

// file: rstboot_ctrl.v
// Purpose: reset sequencing, boot-mode capture, interrupt pin conditioning
// Assumes: i_rst_n is the power-on reset, synchronous to i_clk
// Notes: register writes take effect only after internal reset ends
// Notes: pin_filter at the end is the shared three-stage synchroniser
//
// Our own choices: the register offsets and the address-and-strobe port.
`timescale 1ns/100ps
`include "rstboot_map.vh"

module rstboot_ctrl #(
  parameter RST_DLY = `RB_RST_DLY_CYC
) (
  input wire i_clk, // System clock
  input wire i_rst_n, // Power-on reset, low active
  input wire i_ext_reset_n, // Reset pin, asynchronous
  input wire i_trst_n, // Test-port reset pin, asynchronous
  input wire i_boot_strap, // Boot strap pin
  input wire i_mem_mode_strap, // Memory mode strap pin
  input wire i_flash_secure, // Flash secured state
  input wire i_low_power, // Core in stop or wait
  input wire i_ext_irq_a_n, // Interrupt request pin A
  input wire i_ext_irq_b_n, // Interrupt request pin B
  input wire [1:0] i_td_pin, // Timer D pin levels
  input wire [1:0] i_tmr_out, // Timer D channel outputs
  input wire [1:0] i_tmr_oe, // Timer D channel enables
  input wire [2:0] i_addr, // Register index
  input wire [7:0] i_wdata, // Write data
  input wire i_wr, // Write strobe
  input wire i_rd, // Read strobe
  output reg [7:0] o_rdata, // Read data, cycle after strobe
  output wire o_sys_rst_n, // Internal reset to the device
  output wire o_reset_out_n, // Reset output pin
  output wire o_debug_rst_n, // Debug module reset
  output wire o_op_mode_ma, // Boot mode bit A
  output wire o_op_mode_mb, // Boot mode bit B
  output wire o_emi_addr20, // External 20-bit address bus in use
  output wire [3:0] o_pullup_en, // irq, reset, boot, mem-mode pull-ups
  output wire [1:0] o_port_e_pu, // Port E pin 10/11 pull-ups
  output wire [1:0] o_td_out, // Timer D pin output values
  output wire [1:0] o_td_oe, // Timer D pin output enables
  output wire [1:0] o_irq_req, // Conditioned service requests
  output wire o_wake, // Asynchronous wake request
  output wire o_irq // Interrupt, level
);

  // ----------------------------------------
  // Pin synchronisers
  // ----------------------------------------
  wire ext_filt_q;
  wire trst_filt_q;
  wire boot_filt_q;
  wire mem_filt_q;
  wire ext_irq_a_filt_q;
  wire ext_irq_b_filt_q;

  // Reset pins start from their asserted level
  pin_filter #(
    .RST_VAL(1'b0)
  ) ext_sync_i (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_ext_reset_n),
    .o_level(ext_filt_q)
  );

  pin_filter #(
    .RST_VAL(1'b0)
  ) trst_sync_i (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_trst_n),
    .o_level(trst_filt_q)
  );

  // Straps are only looked at when the reset pin lets go
  pin_filter #(
    .RST_VAL(1'b0)
  ) boot_sync_i (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_boot_strap),
    .o_level(boot_filt_q)
  );

  pin_filter #(
    .RST_VAL(1'b0)
  ) mem_sync_i (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_mem_mode_strap),
    .o_level(mem_filt_q)
  );

  // Interrupt pins idle high, so no false request after reset
  pin_filter #(
    .RST_VAL(1'b1)
  ) ext_irq_a_sync_i (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_ext_irq_a_n),
    .o_level(ext_irq_a_filt_q)
  );

  pin_filter #(
    .RST_VAL(1'b1)
  ) ext_irq_b_sync_i (
    .i_clk(i_clk),
    .i_rst_n(i_rst_n),
    .i_pin(i_ext_irq_b_n),
    .o_level(ext_irq_b_filt_q)
  );

  // ----------------------------------------
  // Reset sequencer
  // ----------------------------------------
  reg int_rst_q;
  reg [15:0] dly_cnt_q;
  reg mode_ma_q;
  reg mode_mb_q;
  reg emi20_q;
  wire cnt_done;
  wire capture_now;
  wire ext_boot;

  assign cnt_done = (dly_cnt_q == RST_DLY[15:0] - 16'h0001);
  // First cycle of the delay count, reached once per release
  assign capture_now = ext_filt_q & int_rst_q & (dly_cnt_q == 16'h0000);
  // Flash security overrides an external boot request
  assign ext_boot = boot_filt_q & ~i_flash_secure;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      int_rst_q <= 1'b1;
      dly_cnt_q <= 16'h0000;
    end else if (!ext_filt_q) begin
      int_rst_q <= 1'b1;
      dly_cnt_q <= 16'h0000;
    end else if (int_rst_q) begin
      if (cnt_done)
        int_rst_q <= 1'b0;
      else
        dly_cnt_q <= dly_cnt_q + 16'h0001;
    end
  end

  // Strap taken in the first cycle after the filtered reset pin lets go
  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      mode_ma_q <= 1'b0;
      mode_mb_q <= 1'b0;
      emi20_q <= 1'b0;
    end else if (capture_now) begin
      mode_mb_q <= ~i_flash_secure;
      mode_ma_q <= ext_boot;
      emi20_q <= ext_boot & mem_filt_q;
    end
  end

  wire sys_rst;
  assign sys_rst = ~i_rst_n | int_rst_q;
  assign o_sys_rst_n = ~sys_rst;
  assign o_reset_out_n = ~sys_rst;
  // Debug reset only from the test-port pin or power-on
  assign o_debug_rst_n = i_rst_n & trst_filt_q;
  assign o_op_mode_ma = mode_ma_q;
  assign o_op_mode_mb = mode_mb_q;
  assign o_emi_addr20 = emi20_q;

  // ----------------------------------------
  // Registers
  // ----------------------------------------
  reg [3:0] pudis_q;
  reg [1:0] pe_pu_q;
  reg [5:0] td_ctl_q;
  reg [1:0] irq_cfg_q;
  reg [1:0] irq_stat_q;
  reg [1:0] irq_mask_q;
  reg [1:0] irq_prev_q;
  reg [1:0] irq_set;
  reg [1:0] irq_stat_d;
  wire [1:0] irq_lvl;

  always @(posedge i_clk) begin
    if (sys_rst) begin
      pudis_q <= `RB_PUDIS_RST;
      pe_pu_q <= `RB_PE_PU_RST;
      td_ctl_q <= `RB_TD_CTL_RST;
      irq_cfg_q <= `RB_IRQ_CFG_RST;
      irq_mask_q <= `RB_IRQ_MASK_RST;
    end else if (i_wr) begin
      case (i_addr)
        `RB_ADDR_PUDIS: pudis_q <= i_wdata[3:0];
        `RB_ADDR_PE_PU: pe_pu_q <= i_wdata[1:0];
        `RB_ADDR_TD_CTL: td_ctl_q <= i_wdata[5:0];
        `RB_ADDR_IRQ_CFG: irq_cfg_q <= i_wdata[1:0];
        `RB_ADDR_IRQ_MASK: irq_mask_q <= i_wdata[1:0];
        default: pudis_q <= pudis_q;
      endcase
    end
  end

  // ----------------------------------------
  // Interrupt conditioning
  // ----------------------------------------
  // Active low pins; cfg bit 1 picks falling edge, 0 picks low level
  assign irq_lvl = {~ext_irq_b_filt_q, ~ext_irq_a_filt_q};

  always @* begin
    irq_set = irq_cfg_q & irq_lvl & ~irq_prev_q;
    irq_set = irq_set | (~irq_cfg_q & irq_lvl);
    irq_stat_d = irq_stat_q;
    if (i_wr && i_addr == `RB_ADDR_IRQ_STAT)
      irq_stat_d = irq_stat_d & ~i_wdata[1:0];
    // A new event wins over a clear in the same cycle
    irq_stat_d = irq_stat_d | irq_set;
  end

  always @(posedge i_clk) begin
    if (sys_rst) begin
      irq_stat_q <= 2'h0;
      irq_prev_q <= 2'h0;
    end else begin
      irq_stat_q <= irq_stat_d;
      irq_prev_q <= irq_lvl;
    end
  end

  assign o_irq_req = irq_stat_q;
  assign o_irq = |(irq_stat_q & irq_mask_q);
  // Raw pins: no clock edge needed to wake the core
  assign o_wake = i_low_power & ~(i_ext_irq_a_n & i_ext_irq_b_n);

  // ----------------------------------------
  // Pin control
  // ----------------------------------------
  assign o_pullup_en[`RB_PUDIS_IRQ] = ~pudis_q[`RB_PUDIS_IRQ];
  assign o_pullup_en[`RB_PUDIS_RESET] = ~pudis_q[`RB_PUDIS_RESET];
  assign o_pullup_en[`RB_PUDIS_BOOT] = ~pudis_q[`RB_PUDIS_BOOT];
  assign o_pullup_en[`RB_PUDIS_MEMMODE] = ~pudis_q[`RB_PUDIS_MEMMODE];
  assign o_port_e_pu = pe_pu_q;
  // td_ctl: [1:0] GPIO select, [3:2] direction, [5:4] output data
  wire [1:0] td_gpio;
  wire [1:0] td_dir;
  wire [1:0] td_dat;

  assign td_gpio = td_ctl_q[1:0];
  assign td_dir = td_ctl_q[3:2];
  assign td_dat = td_ctl_q[5:4];
  assign o_td_oe = (td_gpio & td_dir) | (~td_gpio & i_tmr_oe);
  assign o_td_out = (td_gpio & td_dat) | (~td_gpio & i_tmr_out);

  // ----------------------------------------
  // Read port
  // ----------------------------------------
  always @(posedge i_clk) begin
    if (sys_rst) begin
      o_rdata <= 8'h00;
    end else if (i_rd) begin
      case (i_addr)
        `RB_ADDR_PUDIS: o_rdata <= {4'h0, pudis_q};
        `RB_ADDR_PE_PU: o_rdata <= {6'h00, pe_pu_q};
        `RB_ADDR_TD_CTL: o_rdata <= {2'h0, td_ctl_q};
        `RB_ADDR_IRQ_CFG: o_rdata <= {6'h00, irq_cfg_q};
        `RB_ADDR_IRQ_STAT: o_rdata <= {6'h00, irq_stat_q};
        `RB_ADDR_IRQ_MASK: o_rdata <= {6'h00, irq_mask_q};
        `RB_ADDR_MODE: o_rdata <= {i_td_pin, ext_irq_b_filt_q, ext_irq_a_filt_q,
                                   1'b0, emi20_q, mode_mb_q, mode_ma_q};
        default: o_rdata <= 8'h00;
      endcase
    end else begin
      o_rdata <= 8'h00;
    end
  end

endmodule

// ----------------------------------------
// Three-stage pin filter
// ----------------------------------------
// Level moves only when stages two and three agree, so a
// metastable first stage never reaches the filtered output
module pin_filter #(
  parameter [0:0] RST_VAL = 1'b0
) (
  input wire i_clk, // System clock
  input wire i_rst_n, // Power-on reset, low active
  input wire i_pin, // Asynchronous pin level
  output reg o_level // Filtered level
);

  reg [2:0] stage_q;

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      stage_q <= {3{RST_VAL}};
    end else begin
      stage_q <= {stage_q[1:0], i_pin};
    end
  end

  always @(posedge i_clk) begin
    if (!i_rst_n) begin
      o_level <= RST_VAL;
    end else if (stage_q[1] == stage_q[2]) begin
      o_level <= stage_q[2];
    end
  end

endmodule

// file: rstboot_sva.sv
// Purpose: port checks of rstboot_ctrl
// Assumes: one clock, RST_DLY small in sim
// Notes: bound below
`timescale 1ns/100ps
module rstboot_sva #(parameter RST_DLY = 4) (
  input wire i_clk, // Clock
  input wire i_rst_n, // Power-on reset
  input wire i_ext_reset_n, // Reset pin
  input wire i_trst_n, // Test reset pin
  input wire i_low_power, // Stop or wait
  input wire i_ext_irq_a_n, // Interrupt pin A
  input wire o_sys_rst_n, // Internal reset
  input wire o_reset_out_n, // Reset output pin
  input wire o_debug_rst_n, // Debug reset
  input wire o_op_mode_ma, // Mode bit A
  input wire o_op_mode_mb, // Mode bit B
  input wire o_emi_addr20, // Wide address bus
  input wire [1:0] o_irq_req, // Status bits
  input wire o_wake // Wake request
);
  default clocking cb @(posedge i_clk); endclocking
  default disable iff (!i_rst_n);

  // Cycles since the reset pin let go, saturating
  reg [7:0] pin_hi_cnt_q;

  always @(posedge i_clk) begin
    if (!i_rst_n || !i_ext_reset_n)
      pin_hi_cnt_q <= 8'h00;
    else if (pin_hi_cnt_q != 8'hFF)
      pin_hi_cnt_q <= pin_hi_cnt_q + 8'h01;
  end

  a_rstout_follows: assert property (o_reset_out_n == o_sys_rst_n)
    else $error("reset out differs");
  a_por_holds: assert property ($rose(i_rst_n) |-> !o_sys_rst_n [*3])
    else $error("por short");
  a_pin_holds: assert property ((!i_ext_reset_n) [*7] |-> !o_sys_rst_n)
    else $error("pin reset lost");
  a_release_late: assert property ($rose(i_ext_reset_n) |-> !o_sys_rst_n [*6])
    else $error("release early");
  a_release_bound: assert property (pin_hi_cnt_q >= RST_DLY + 5 |-> o_sys_rst_n)
    else $error("release late");
  a_mode_legal: assert property (
    (o_op_mode_ma |-> o_op_mode_mb) and (o_emi_addr20 |-> o_op_mode_ma))
    else $error("bad mode");
  a_debug_kept: assert property (i_trst_n [*6] |-> o_debug_rst_n)
    else $error("debug reset");
  a_wake_async: assert property (i_low_power && !i_ext_irq_a_n |-> o_wake)
    else $error("no wake");
  a_irq_synced: assert property (
    $fell(i_ext_irq_a_n) && !o_irq_req[0] |=> !o_irq_req[0] [*2])
    else $error("irq unsynced");
endmodule
bind rstboot_ctrl rstboot_sva #(
  .RST_DLY(RST_DLY)
) rstboot_sva_i (
  .i_clk(i_clk),
  .i_rst_n(i_rst_n),
  .i_ext_reset_n(i_ext_reset_n),
  .i_trst_n(i_trst_n),
  .i_low_power(i_low_power),
  .i_ext_irq_a_n(i_ext_irq_a_n),
  .o_sys_rst_n(o_sys_rst_n),
  .o_reset_out_n(o_reset_out_n),
  .o_debug_rst_n(o_debug_rst_n),
  .o_op_mode_ma(o_op_mode_ma),
  .o_op_mode_mb(o_op_mode_mb),
  .o_emi_addr20(o_emi_addr20),
  .o_irq_req(o_irq_req),
  .o_wake(o_wake)
);

// file: rb_board.sv
// Purpose: board reset, straps, irq sources
// Assumes: straps are hard tied
// Notes: keep_debug spares test reset
`timescale 1ns/100ps
module rb_board (
  input wire i_reset, // req
  input wire i_keep_debug, // spare
  input wire i_boot_ext, // strap
  input wire i_mem20, // strap
  input wire [1:0] i_irq, // src
  output wire o_ext_reset_n, // pin
  output wire o_trst_n, // pin
  output wire o_boot_strap, // pin
  output wire o_mem_mode_strap, // pin
  output wire o_irq_a_n, // pin
  output wire o_irq_b_n // pin
);
  assign o_ext_reset_n = !i_reset;
  assign o_trst_n = !(i_reset && !i_keep_debug);
  assign o_boot_strap = i_boot_ext;
  assign o_mem_mode_strap = i_mem20;
  assign o_irq_a_n = !i_irq[0];
  assign o_irq_b_n = !i_irq[1];
endmodule

// file: testbench.sv
// Purpose: directed test of rstboot_ctrl
// Assumes: RST_DLY of 4
// Notes: straps change only in reset
`timescale 1ns/100ps
module testbench;
  reg i_clk = 1'h0, i_rst_n = 1'h0, i_flash_secure = 1'h0, i_low_power = 1'h0;
  reg i_wr = 1'h0, i_rd = 1'h0, rq_rst = 1'h0, keep_dbg = 1'h0, boot_ext = 1'h1, mem20 = 1'h1;
  reg [1:0] irq = 2'h0, i_td_pin = 2'h2, i_tmr_out = 2'h1, i_tmr_oe = 2'h2;
  reg [2:0] i_addr = 3'h0, expm;
  reg [7:0] i_wdata = 8'h00;
  wire i_ext_reset_n, i_trst_n, i_boot_strap, i_mem_mode_strap, i_ext_irq_a_n, i_ext_irq_b_n;
  wire o_sys_rst_n, o_reset_out_n, o_debug_rst_n, o_op_mode_ma, o_op_mode_mb, o_emi_addr20;
  wire o_wake, o_irq;
  wire [7:0] o_rdata;
  wire [3:0] o_pullup_en;
  wire [1:0] o_port_e_pu, o_td_out, o_td_oe, o_irq_req;
  integer miscompares = 0, checked = 0, n, k;
  localparam [17:0] MODE_TBL = {6'h0A, 6'h13, 6'h38};
  always #5 i_clk = ~i_clk;
  rb_board rb_board_i (.i_reset(rq_rst), .i_keep_debug(keep_dbg), .i_boot_ext(boot_ext),
    .i_mem20(mem20), .i_irq(irq), .o_ext_reset_n(i_ext_reset_n), .o_trst_n(i_trst_n),
    .o_boot_strap(i_boot_strap), .o_mem_mode_strap(i_mem_mode_strap),
    .o_irq_a_n(i_ext_irq_a_n), .o_irq_b_n(i_ext_irq_b_n));
  rstboot_ctrl #(.RST_DLY(4)) rstboot_ctrl_i (.i_clk(i_clk), .i_rst_n(i_rst_n),
    .i_ext_reset_n(i_ext_reset_n), .i_trst_n(i_trst_n), .i_boot_strap(i_boot_strap),
    .i_mem_mode_strap(i_mem_mode_strap), .i_flash_secure(i_flash_secure),
    .i_low_power(i_low_power), .i_ext_irq_a_n(i_ext_irq_a_n), .i_ext_irq_b_n(i_ext_irq_b_n),
    .i_td_pin(i_td_pin), .i_tmr_out(i_tmr_out), .i_tmr_oe(i_tmr_oe), .i_addr(i_addr),
    .i_wdata(i_wdata), .i_wr(i_wr), .i_rd(i_rd), .o_rdata(o_rdata), .o_sys_rst_n(o_sys_rst_n),
    .o_reset_out_n(o_reset_out_n), .o_debug_rst_n(o_debug_rst_n),
    .o_op_mode_ma(o_op_mode_ma), .o_op_mode_mb(o_op_mode_mb), .o_emi_addr20(o_emi_addr20),
    .o_pullup_en(o_pullup_en), .o_port_e_pu(o_port_e_pu), .o_td_out(o_td_out),
    .o_td_oe(o_td_oe), .o_irq_req(o_irq_req), .o_wake(o_wake), .o_irq(o_irq));
  task cyc(input integer c);
    repeat (c) @(posedge i_clk);
  endtask
  task check(input string nm, input [7:0] seen, input [7:0] exp);
    begin
      checked = checked + 1;
      if (seen !== exp) begin
        miscompares = miscompares + 1;
        $display("BAD %s exp %h seen %h", nm, exp, seen);
      end
    end
  endtask
  // Strobe drops with a spare cycle, so calls never collide
  task wr_reg(input [2:0] a, input [7:0] d);
    begin
      i_addr <= a;
      i_wdata <= d;
      i_wr <= 1'h1;
      @(posedge i_clk);
      i_wr <= 1'h0;
      @(posedge i_clk);
    end
  endtask
  task rd_chk(input string nm, input [2:0] a, input [7:0] exp);
    begin
      i_addr <= a;
      i_rd <= 1'h1;
      @(posedge i_clk);
      i_rd <= 1'h0;
      #1 check(nm, o_rdata, exp);
      @(posedge i_clk);
    end
  endtask
  task wait_sys;
    begin
      n = 0;
      while (o_sys_rst_n !== 1'h1 && n < 200) begin
        @(posedge i_clk);
        n = n + 1;
      end
      if (n >= 200) miscompares = miscompares + 1;
      @(posedge i_clk);
    end
  endtask
  task finish_test;
    begin
      $display("checked %0d miscompares %0d", checked, miscompares);
      if (miscompares == 0 && checked > 0)
        $display("== PASSED ==");
      else
        $display("== FAILED ==");
      $finish;
    end
  endtask
  initial begin
    #60000;
    miscompares = miscompares + 1;
    finish_test;
  end
  initial begin
    cyc(10);
    i_rst_n <= 1'h1;
    wait_sys;
    rd_chk("pudis", 3'h0, 8'h00);
    rd_chk("pe_pu", 3'h1, 8'h03);
    rd_chk("unmapped", 3'h7, 8'h00);
    rd_chk("td_ctl", 3'h2, 8'h00);
    wr_reg(3'h6, 8'h00);
    rd_chk("mode", 3'h6, 8'hB7);
    wr_reg(3'h0, 8'h0F);
    check("pullups", {4'h0, o_pullup_en}, 8'h00);
    wr_reg(3'h1, 8'h02);
    check("pe_pu", {6'h0, o_port_e_pu}, 8'h02);
    check("td", {4'h0, o_td_oe, o_td_out}, 8'h09);
    wr_reg(3'h2, 8'h2D);
    check("td", {4'h0, o_td_oe, o_td_out}, 8'h0C);
    wr_reg(3'h5, 8'h03);
    wr_reg(3'h3, 8'h01);
    irq <= 2'h3;
    cyc(8);
    check("irq", {5'h0, o_irq, o_irq_req}, 8'h07);
    wr_reg(3'h4, 8'h03);
    check("irq", {5'h0, o_irq, o_irq_req}, 8'h06);
    irq <= 2'h0;
    cyc(8);
    wr_reg(3'h4, 8'h03);
    wr_reg(3'h5, 8'h00);
    irq <= 2'h2;
    cyc(8);
    check("masked", {5'h0, o_irq, o_irq_req}, 8'h02);
    i_low_power <= 1'h1;
    irq <= 2'h1;
    cyc(1);
    check("wake", {7'h0, o_wake}, 8'h01);
    i_low_power <= 1'h0;
    irq <= 2'h0;
    cyc(8);
    check("wake off", {7'h0, o_wake}, 8'h00);
    for (k = 0; k < 3; k = k + 1) begin
      {i_flash_secure, boot_ext, mem20, expm} <= MODE_TBL[k * 6 +: 6];
      keep_dbg <= k[0];
      rq_rst <= 1'h1;
      cyc(10);
      check("in reset", {6'h0, o_debug_rst_n, o_reset_out_n},
            {6'h0, k[0], 1'h0});
      rq_rst <= 1'h0;
      wait_sys;
      rd_chk("mode", 3'h6, {5'h16, expm});
      check("mode pins", {5'h0, o_emi_addr20, o_op_mode_mb, o_op_mode_ma},
            {5'h0, expm});
    end
    i_rst_n <= 1'h0;
    cyc(3);
    check("por", {7'h0, o_sys_rst_n}, 8'h00);
    i_rst_n <= 1'h1;
    wait_sys;
    rd_chk("pe_pu", 3'h1, 8'h03);
    finish_test;
  end
endmodule
